/* src/sar_dev.sv */
// converter end: frame decode, conversion, calibration and result shift-out
// Operation
// (RULE1) power-up starts in acquire state, switches closed
// (RULE2) frame spans chip select low to high
// (RULE3) sdo floats while chip select is high
// (RULE4) chip select fall samples, enters convert state
// (RULE5) conversion timed only by serial clock
// (RULE6) host gives at least 18 falling edges
// (RULE7) after 18 clocks return to acquire state
// (RULE8) host waits acquisition time before next frame
// (RULE9) first frame after power-up outputs zeros
// (RULE10) frame shifts out previous frame's result
// (RULE11) chip select fall drives leading zero
// (RULE12) msb on rising edge after first fall
// (RULE13) zeros after all 14 result bits
// (RULE14) short frame makes next result invalid
// (RULE15) results are straight unsigned binary
// (RULE16) codes 0000, 1fff, 2000, 3fff ideal
// (RULE17) calibration disconnects sampling capacitors from inputs
// (RULE18) finished calibration returns to acquire state
// (RULE19) offset correction kept until power off
// (RULE20) host calibrates at power-up and on drift
// (RULE21) 24-clock first frame calibrates, sdo zeros
// (RULE22) 64-clock frame calibrates after result shift-out
// (RULE23) early chip select rise aborts calibration
// (RULE24) reset clears shift register, selects acquire
module sar_dev #(
  parameter int unsigned RES_W = sar_pkg::RES_W
) (
  sar_link_if.dev link,
  input wire logic srst,
  input wire logic [RES_W-1:0] ain_code,
  input wire logic [RES_W-1:0] cal_offset_code,
  output logic sample_closed,
  output logic cal_busy,
  output logic [1:0] dev_state,
  output logic [RES_W-1:0] offset_out,
  output logic offset_valid,
  output logic result_ok
);

  //////////////////////////////////////////////////////////////////////////////
  // state record

  typedef struct packed {
    sar_pkg::sar_dev_state_e state;
    logic in_frame;
    logic first;
    logic [sar_pkg::CNT_W-1:0] cnt;
    logic [RES_W-1:0] shft;
    logic sdo;
    logic [RES_W-1:0] result;
    logic res_ok;
    logic [RES_W-1:0] sar;
    logic [RES_W-1:0] mask;
    logic [RES_W-1:0] target;
    logic [RES_W-1:0] offset;
    logic cal_valid;
  } sar_dev_s;

  sar_dev_s r;
  sar_dev_s n;
  logic [sar_pkg::CNT_W-1:0] cnt_inc;
  logic [RES_W-1:0] trial;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // offset-corrected sample, clamped at the bottom code
  function automatic logic [RES_W-1:0] corrected(
    input logic [RES_W-1:0] code,
    input logic [RES_W-1:0] off
  );
    logic [RES_W-1:0] diff;
    diff = code - off;
    if (code > off) begin
      corrected = diff;
    end else begin
      corrected = sar_pkg::NEGATIVE_FULL_SCALE_CODE;
    end
  endfunction

  // calibration length depends on whether this is the first frame
  // (RULE21) first frame after power-up calibrates in 24 clocks
  function automatic logic [sar_pkg::CNT_W-1:0] cal_len(input logic first_frame);
    if (first_frame) begin
      cal_len = sar_pkg::CAL_FIRST_CLKS;
    end else begin
      cal_len = sar_pkg::CAL_NORM_CLKS;
    end
  endfunction

  // frame clock count saturates so long frames never wrap into a new phase
  assign cnt_inc = (r.cnt == sar_pkg::CNT_MAX) ? r.cnt : r.cnt + sar_pkg::ONE_CLK;
  assign trial = r.sar | r.mask;

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic; every edge here is a serial clock rising edge

  always_comb begin
    n = r;
    if (link.cs_n) begin
      // (RULE2) chip select high closes the frame
      n.in_frame = 1'b0;
      n.sdo = 1'b0;
      n.cnt = '0;
      if (r.in_frame) begin
        n.first = 1'b0;
        if (r.state == sar_pkg::convert_state) begin
          // (RULE14) short frame keeps a partial, invalid code
          n.result = r.sar;
          n.res_ok = 1'b0;
          n.state = sar_pkg::acquire_state;
        end
        if (r.state == sar_pkg::offset_cal_state) begin
          // (RULE23) early rise aborts calibration
          n.state = sar_pkg::acquire_state;
        end
      end
    end else if (!r.in_frame) begin
      // (RULE4) frame start holds the sample and starts converting
      n.in_frame = 1'b1;
      n.cnt = sar_pkg::ONE_CLK;
      n.state = sar_pkg::convert_state;
      // (RULE19) stored offset corrects every conversion
      n.target = corrected(ain_code, r.offset);
      // (RULE16) search starts at zero, msb weighs just above mid-scale
      n.sar = sar_pkg::NEGATIVE_FULL_SCALE_CODE;
      n.mask = sar_pkg::SAR_MSB;
      // (RULE12) msb of the previous result goes out first
      n.sdo = r.result[RES_W-1];
      // (RULE10) shifter carries the preceding frame's result
      n.shft = {r.result[RES_W-2:0], 1'b0};
    end else begin
      n.cnt = cnt_inc;
      // (RULE13) zeros fill in once the shifter is empty
      n.sdo = r.shft[RES_W-1];
      n.shft = {r.shft[RES_W-2:0], 1'b0};
      case (r.state)
        sar_pkg::convert_state: begin
          // (RULE5) one approximation step per serial clock, clocks SAR_FIRST to SAR_LAST only
          if (cnt_inc >= sar_pkg::SAR_FIRST && cnt_inc <= sar_pkg::SAR_LAST) begin
            if (trial <= r.target) begin
              n.sar = trial;
            end
            n.mask = r.mask >> 1;
          end
          // (RULE7) conversion done, back to acquisition
          if (cnt_inc == sar_pkg::CONV_CLKS) begin
            // (RULE15) code stored as plain binary
            n.result = r.sar;
            n.res_ok = 1'b1;
            n.state = sar_pkg::acquire_state;
          end
        end
        sar_pkg::acquire_state: begin
          // (RULE22) clocking past the conversion enters calibration
          if (cnt_inc == sar_pkg::CAL_ENTER) begin
            n.state = sar_pkg::offset_cal_state;
          end
        end
        sar_pkg::offset_cal_state: begin
          // (RULE18) full calibration count stores offset, returns
          if (cnt_inc == cal_len(r.first)) begin
            n.offset = cal_offset_code;
            n.cal_valid = 1'b1;
            n.state = sar_pkg::acquire_state;
          end
        end
        default: begin
          n.state = sar_pkg::acquire_state;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register on the serial clock; srst stands for power-on

  always_ff @(posedge link.sclk) begin
    if (srst) begin
      // (RULE24) power-on clears shifter and result
      r <= '0;
      // (RULE1) power-up in acquisition
      r.state <= sar_pkg::acquire_state;
      // (RULE9) first frame result is all zeros
      r.result <= sar_pkg::NEGATIVE_FULL_SCALE_CODE;
      r.first <= 1'b1;
    end else begin
      r <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pins and status

  // (RULE3) driver enabled only while chip select is low
  assign link.sdo_oe = !link.cs_n;
  // (RULE11) leading zero until the first rising edge of the frame
  assign link.sdo = !link.cs_n && r.in_frame && r.sdo;
  // (RULE17) switches open outside acquisition
  assign sample_closed = (r.state == sar_pkg::acquire_state);
  assign cal_busy = (r.state == sar_pkg::offset_cal_state);
  assign dev_state = r.state;
  assign offset_out = r.offset;
  assign offset_valid = r.cal_valid;
  assign result_ok = r.res_ok;

endmodule

/* src/sar_pkg.sv */
// shared constants and types for the serial converter link
package sar_pkg;

  // result width and frame clock counts
  localparam int unsigned RES_W = 14;
  localparam int unsigned CNT_W = 7;
  localparam logic [6:0] CONV_CLKS = 7'h12;      // 18 clocks finish a conversion
  localparam logic [6:0] CAL_ENTER = 7'h13;      // first clock past the conversion
  localparam logic [6:0] CAL_FIRST_CLKS = 7'h18; // 24 clocks, first frame after power-up
  localparam logic [6:0] CAL_NORM_CLKS = 7'h40;  // 64 clocks, normal operation
  localparam logic [6:0] CNT_MAX = 7'h7f;
  localparam logic [6:0] SAR_FIRST = 7'h02;      // clock that decides the msb
  localparam logic [6:0] SAR_LAST = 7'h0f;       // clock that decides the lsb
  localparam logic [6:0] ONE_CLK = 7'h01;

  // ideal result codes, straight binary
  localparam logic [13:0] NEGATIVE_FULL_SCALE_CODE = 14'h0000;
  localparam logic [13:0] MID_SCALE_CODE = 14'h1fff;
  localparam logic [13:0] POSITIVE_FULL_SCALE_CODE = 14'h3fff;
  localparam logic [13:0] SAR_MSB = 14'h2000;

  // host timing: acquisition time in ns against the 100 ns system clock
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned T_ACQ_NS = 95;
  localparam int unsigned ACQ_CYC = (T_ACQ_NS + CLK_NS - 1) / CLK_NS;

  // device states
  typedef enum logic [1:0] {
    acquire_state,
    convert_state,
    offset_cal_state
  } sar_dev_state_e;

  // host sequencer states
  typedef enum logic [2:0] {
    h_idle,
    h_arm,
    h_run,
    h_end,
    h_gap
  } sar_host_state_e;

endpackage

/* src/sar_link_if.sv */
// serial link between the host and the converter
interface sar_link_if;
  logic cs_n;
  logic sclk;
  logic sdo;
  logic sdo_oe;
  wire sdo_wire;

  // pin level as the host sees it; no pull is fitted, so a released line reads low,
  // which is harmless because the host samples only inside a frame
  assign sdo_wire = sdo_oe & sdo;

  modport dev (
    input cs_n,
    input sclk,
    output sdo,
    output sdo_oe
  );

  modport host (
    output cs_n,
    output sclk,
    input sdo_wire
  );
endinterface

/* src/sar_host.sv */
// host end: divides its clock into the serial clock and runs frames
module sar_host #(
  parameter int unsigned RES_W = sar_pkg::RES_W,
  parameter int unsigned SCLK_HALF = 4
) (
  input wire logic clk,
  input wire logic srst,
  sar_link_if.host link,
  input wire logic start,
  input wire logic [sar_pkg::CNT_W-1:0] nclk,
  output logic busy,
  output logic [RES_W-1:0] data_out,
  output logic data_valid
);

  localparam logic [7:0] DIV_LAST = 8'(SCLK_HALF - 1);
  localparam logic [7:0] DIV_MID = 8'(SCLK_HALF / 2);
  localparam logic [7:0] GAP_CYC = 8'(2 * SCLK_HALF + sar_pkg::ACQ_CYC);

  typedef struct packed {
    sar_pkg::sar_host_state_e state;
    logic [7:0] div;
    logic sclk;
    logic cs_n;
    logic [sar_pkg::CNT_W-1:0] nclk;
    logic [sar_pkg::CNT_W-1:0] fall;
    logic [sar_pkg::CNT_W-1:0] rise;
    logic [RES_W-1:0] shreg;
    logic [RES_W-1:0] data;
    logic valid;
    logic [7:0] gap;
    logic s1;
    logic s2;
  } sar_host_s;

  sar_host_s r;
  sar_host_s n;
  logic tick;
  logic mid_high;
  logic [sar_pkg::CNT_W-1:0] fall_inc;
  logic [sar_pkg::CNT_W-1:0] rise_inc;

  //////////////////////////////////////////////////////////////////////////////
  // divider events; the serial clock runs free so the far end sees frame ends

  assign tick = (r.div == DIV_LAST);
  assign mid_high = r.sclk && (r.div == DIV_MID);
  assign fall_inc = r.fall + sar_pkg::ONE_CLK;
  assign rise_inc = r.rise + sar_pkg::ONE_CLK;

  // frame sequencer; chip select moves mid high phase for setup and hold margin
  always_comb begin
    n = r;
    n.valid = 1'b0;
    n.s1 = link.sdo_wire;
    n.s2 = r.s1;
    n.div = tick ? 8'h00 : r.div + 8'h01;
    n.sclk = tick ? !r.sclk : r.sclk;
    case (r.state)
      sar_pkg::h_idle: begin
        if (start) begin
          n.nclk = nclk;
          n.state = sar_pkg::h_arm;
        end
      end
      sar_pkg::h_arm: begin
        // (RULE2) chip select fall opens the frame
        if (mid_high) begin
          n.cs_n = 1'b0;
          n.fall = '0;
          n.rise = '0;
          n.shreg = '0;
          n.state = sar_pkg::h_run;
        end
      end
      sar_pkg::h_run: begin
        if (tick && r.sclk) begin
          // falling edge: bits launched at the previous rise are settled
          n.fall = fall_inc;
          if (fall_inc >= sar_pkg::SAR_FIRST && fall_inc <= sar_pkg::SAR_LAST) begin
            n.shreg = {r.shreg[RES_W-2:0], r.s2};
          end
        end
        if (tick && !r.sclk) begin
          n.rise = rise_inc;
          // (RULE6) frame runs nclk clocks; 18 or more completes a conversion
          if (rise_inc == r.nclk) begin
            n.state = sar_pkg::h_end;
          end
        end
      end
      sar_pkg::h_end: begin
        if (mid_high) begin
          n.cs_n = 1'b1;
          n.data = r.shreg;
          n.valid = 1'b1;
          n.gap = '0;
          n.state = sar_pkg::h_gap;
        end
      end
      sar_pkg::h_gap: begin
        // (RULE8) hold chip select high past the acquisition time
        n.gap = r.gap + 8'h01;
        if (r.gap == GAP_CYC) begin
          n.state = sar_pkg::h_idle;
        end
      end
      default: begin
        n.state = sar_pkg::h_idle;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
      r.state <= sar_pkg::h_idle;
      r.sclk <= 1'b1;
      r.cs_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.sclk = r.sclk;
  assign link.cs_n = r.cs_n;
  assign busy = (r.state != sar_pkg::h_idle);
  assign data_out = r.data;
  assign data_valid = r.valid;

endmodule

/* dv/sar_link_props.sv */
// checker for the serial link: tri-state, framing, gap and bit slots
module sar_link_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic dev_srst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] rise_cnt_r;
  logic first_r;
  ////////////////////////////////////////////////////////////////////////////////
  // rising edges seen in the frame; saturates so long calibration frames stay quiet
  always_ff @(posedge sclk) begin
    if (dev_srst) begin
      rise_cnt_r <= 7'h00;
      first_r <= 1'h1;
    end else begin
      rise_cnt_r <= cs_n ? 7'h00 : rise_cnt_r + {6'h00, rise_cnt_r != 7'h7f};
      first_r <= first_r & ~(cs_n & (rise_cnt_r != 7'h00));
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // device side, sampled on the link clock
  oe_idle_off_a: assert property (@(posedge sclk) disable iff (dev_srst) cs_n |-> !sdo_oe)
    else $error("sdo enabled while chip select high");
  oe_frame_on_a: assert property (@(posedge sclk) disable iff (dev_srst) !cs_n |-> sdo_oe)
    else $error("sdo not driven inside frame");
  lead_zero_a: assert property (@(posedge sclk) disable iff (dev_srst)
    !cs_n && rise_cnt_r == 7'h00 |-> !sdo) else $error("leading bit not zero");
  tail_zero_a: assert property (@(posedge sclk) disable iff (dev_srst)
    !cs_n && rise_cnt_r >= 7'h0e |=> !sdo) else $error("sdo not zero after result bits");
  first_frame_zero_a: assert property (@(posedge sclk) disable iff (dev_srst)
    first_r |-> !sdo) else $error("first frame after reset not all zeros");
  // host side; cs_n must move only while sclk is high to keep setup and hold
  cs_fall_high_a: assert property (@(posedge clk) disable iff (srst)
    $fell(cs_n) |-> sclk && $past(sclk)) else $error("frame opened outside sclk high");
  cs_rise_high_a: assert property (@(posedge clk) disable iff (srst)
    $rose(cs_n) |-> sclk && $past(sclk)) else $error("frame closed outside sclk high");
  acq_gap_a: assert property (@(posedge clk) disable iff (srst)
    $rose(cs_n) |-> cs_n [*8]) else $error("chip select gap too short");
  sdo_steady_a: assert property (@(posedge clk) disable iff (srst)
    !sclk && !$past(sclk) && !cs_n && !$past(cs_n) |-> $stable(sdo))
    else $error("sdo moved while sclk low");
endmodule

/* dv/tb_top.sv */
// self-checking bench: host and converter ends joined over the serial link
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, dev_srst, start, busy, data_valid, valid_f, first_f;
  logic sample_closed, cal_busy, offset_valid, result_ok;
  logic [1:0] dev_state;
  logic [6:0] nclk;
  logic [13:0] ain_code, cal_offset_code, data_out, offset_out, exp_code, cur_off;
  int n_fail, samples_checked, cyc;
  sar_link_if link ();
  sar_host i_sar_host (.clk(clk), .srst(srst), .link(link), .start(start), .nclk(nclk),
    .busy(busy), .data_out(data_out), .data_valid(data_valid));
  sar_dev i_sar_dev (.link(link), .srst(dev_srst), .ain_code(ain_code),
    .cal_offset_code(cal_offset_code), .sample_closed(sample_closed), .cal_busy(cal_busy),
    .dev_state(dev_state), .offset_out(offset_out), .offset_valid(offset_valid),
    .result_ok(result_ok));
  sar_link_props i_sar_link_props (.clk(clk), .srst(srst), .dev_srst(dev_srst),
    .cs_n(link.cs_n), .sclk(link.sclk), .sdo(link.sdo), .sdo_oe(link.sdo_oe));
  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz system clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // cycle ceiling: a hung handshake ends the run as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    samples_checked++;
    if (exp !== got) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (exp !== got) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  // offset is removed at sampling; codes below the offset clamp to zero
  function automatic logic [13:0] conv(input logic [13:0] a, input logic [13:0] off);
    return (a > off) ? a - off : 14'h0000;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // one host frame of n clocks; a short frame spoils the next result, so skip it
  task automatic frame(input logic [6:0] n, input logic [13:0] a);
    int k;
    logic cnv_seen;
    logic cal_seen;
    k = 0;
    cnv_seen = 1'h0;
    cal_seen = 1'h0;
    chk_bit("sample_closed", 1'h1, sample_closed);
    ain_code <= a;
    nclk <= n;
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    while (data_valid !== 1'h1 && k < 2000) begin
      @(posedge clk);
      k++;
      if (dev_state === sar_pkg::convert_state) cnv_seen = 1'h1;
      if (cal_busy === 1'h1) cal_seen = 1'h1;
      if (cal_busy === 1'h1) chk_bit("sample_closed", 1'h0, sample_closed);
    end
    if (valid_f && n >= 7'h0f) chk("data_out", exp_code, data_out);
    while (busy !== 1'h0 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    chk_bit("frame finished", 1'h1, k < 4000);
    chk_bit("convert seen", 1'h1, cnv_seen);
    chk_bit("cal entered", n >= 7'h13, cal_seen);
    chk("dev_state", {12'h000, sar_pkg::acquire_state}, {12'h000, dev_state});
    chk_bit("cal_busy", 1'h0, cal_busy);
    chk_bit("result_ok", n >= 7'h12, result_ok);
    chk_bit("sdo_oe", 1'h0, link.sdo_oe);
    exp_code = conv(a, cur_off);
    if ((first_f && n >= 7'h18) || n >= 7'h40) cur_off = cal_offset_code;
    chk("offset_out", cur_off, offset_out);
    valid_f = n >= 7'h12;
    first_f = 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: power-up calibration, code corners, random frames, faults
  initial begin
    srst = 1'h1;
    dev_srst = 1'h1;
    start = 1'h0;
    nclk = 7'h12;
    ain_code = 14'h0000;
    cal_offset_code = 14'h0000;
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    valid_f = 1'h1;
    first_f = 1'h1;
    exp_code = 14'h0000;
    cur_off = 14'h0000;
    void'($urandom(20));
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    // device reset needs link clock edges, which run only once the host is out
    repeat (20) @(posedge clk);
    dev_srst <= 1'h0;
    repeat (2) @(posedge clk);
    cal_offset_code <= 14'($urandom_range(1, 15));
    frame(7'h18, 14'($urandom));
    chk_bit("offset_valid", 1'h1, offset_valid);
    frame(7'h12, cur_off);
    frame(7'h12, cur_off + 14'h1fff);
    frame(7'h12, cur_off + 14'h2000);
    frame(7'h12, 14'h3fff);
    // random frames keep 18 clocks or more
    for (int i = 0; i < 20; i++) begin
      frame(7'($urandom_range(18, 40)), 14'($urandom));
    end
    frame(7'h0a, 14'h2aaa);
    frame(7'h12, 14'h1555);
    cal_offset_code <= 14'($urandom_range(16, 31));
    frame(7'h40, 14'($urandom));
    frame(7'h13, 14'h3fff);
    frame(7'h12, 14'h0000);
    print_verdict();
  end
endmodule
